// [hw/bse_host.sv]
`timescale 1ns/1ps
`include "bse_map.svh"
module bse_host
    import bse_pkg::*;
#(
    parameter int POLL_LIMIT = `BSE_POLL_LIMIT,
    parameter int PHASE = `BSE_PHASE_CYCLES
)(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic START,
    input wire logic WRITE,
    input wire logic [15:0] ADDR,
    input wire logic [6:0] COUNT,
    input wire logic [7:0] WDATA,
    output logic WDATA_TAKE,
    output logic [7:0] RDATA,
    output logic RDATA_VALID,
    output logic BUSY,
    output logic DONE,
    output logic TIMEOUT,
    output logic CE_N,
    output logic OE_N,
    output logic WE_N,
    input wire logic IO_IN,
    output logic IO_OUT,
    output logic IO_OE_N
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        bse_state_e st;
        bse_cyc_e cyc;
        logic [3:0] ph;
        logic bit_val;
        logic [4:0] nbit;
        logic [6:0] nbyte;
        logic [6:0] count;
        logic wr;
        logic [15:0] addr;
        logic [7:0] shreg;
        logic [7:0] rdata;
        logic rvalid;
        logic take;
        logic done;
        logic tmo;
        logic [31:0] poll;
        logic sync1;
        logic sync2;
        logic cen;
        logic oen;
        logic wen;
        logic dout;
        logic doen;
    } bse_state_s;
    bse_state_s r, next_r;
    logic cyc_end;

    // one strobe low phase then one high phase per bus cycle
    assign cyc_end = (r.cyc != BSE_CYC_NONE) && (r.ph == 4'(2 * PHASE - 1));

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.sync1 = IO_IN;
        next_r.sync2 = r.sync1;
        next_r.rvalid = 1'b0;
        next_r.take = 1'b0;
        next_r.done = 1'b0;
        // strobe generation: select held high between cycles [R20]
        if (r.cyc != BSE_CYC_NONE)
        begin
            next_r.ph = r.ph + 4'h1;
            if (r.ph == 4'(PHASE - 1))
            begin
                // write strobe rises first; data still held [R3]
                next_r.wen = 1'b1;
                next_r.oen = 1'b1;
            end
            if (r.ph == 4'(PHASE))
            begin
                next_r.cen = 1'b1;
                next_r.doen = 1'b1;
            end
            if (cyc_end)
            begin
                next_r.cyc = BSE_CYC_NONE;
            end
        end
        if (r.cyc == BSE_CYC_NONE || cyc_end)
        begin
            // issue next bus cycle according to state
            case (r.st)
                BSE_IDLE:
                begin
                    if (START)
                    begin
                        next_r.wr = WRITE;
                        next_r.addr = ADDR;
                        next_r.count = (COUNT == 7'h00) ? 7'h01 : COUNT;
                        next_r.nbyte = 7'h00;
                        next_r.nbit = 5'h00;
                        next_r.tmo = 1'b0;
                        next_r.st = BSE_RST_RD1; // reset first [R13]
                    end
                end
                BSE_RST_RD1:
                begin
                    next_r.cyc = BSE_CYC_RD; // [R10]
                    next_r.st = BSE_RST_WR0;
                end
                BSE_RST_WR0:
                begin
                    next_r.cyc = BSE_CYC_WR;
                    next_r.bit_val = 1'b0; // [R10] [R11]
                    next_r.st = BSE_RST_RD2;
                end
                BSE_RST_RD2:
                begin
                    next_r.cyc = BSE_CYC_RD; // [R12]
                    next_r.st = BSE_ADDR;
                end
                BSE_ADDR:
                begin
                    // sixteen writes, MSB first, no reads between [R6] [R23]
                    next_r.cyc = BSE_CYC_WR;
                    next_r.bit_val = r.addr[15 - r.nbit[3:0]];
                    next_r.nbit = r.nbit + 5'h01;
                    if (r.nbit == 5'(`BSE_ADDR_BITS - 1))
                    begin
                        next_r.nbit = 5'h00;
                        next_r.shreg = WDATA;
                        next_r.take = r.wr;
                        next_r.st = r.wr ? BSE_WDATA : BSE_RDATA;
                    end
                end
                BSE_WDATA:
                begin
                    // whole bytes only; host stops after 64 bytes, page boundary not checked [R14] [R16] [R17]
                    next_r.cyc = BSE_CYC_WR;
                    next_r.bit_val = r.shreg[7];
                    next_r.shreg = {r.shreg[6:0], 1'b0};
                    next_r.nbit = r.nbit + 5'h01;
                    if (r.nbit == 5'(`BSE_BYTE_BITS - 1))
                    begin
                        next_r.nbit = 5'h00;
                        next_r.nbyte = r.nbyte + 7'h01;
                        if (r.nbyte + 7'h01 == r.count || r.nbyte == 7'(`BSE_PAGE_BYTES - 1))
                        begin
                            next_r.st = BSE_PG_RD1;
                        end
                        else
                        begin
                            next_r.shreg = WDATA;
                            next_r.take = 1'b1;
                        end
                    end
                end
                BSE_RDATA:
                begin
                    // eight reads per byte, device increments address [R7] [R9]
                    if (r.nbit != 5'h00)
                    begin
                        next_r.shreg = {r.shreg[6:0], r.sync2};
                    end
                    if (r.nbit == 5'(`BSE_BYTE_BITS))
                    begin
                        next_r.nbit = 5'h00;
                        next_r.rdata = {r.shreg[6:0], r.sync2};
                        next_r.rvalid = 1'b1;
                        next_r.nbyte = r.nbyte + 7'h01;
                        if (r.nbyte + 7'h01 == r.count)
                        begin
                            next_r.st = BSE_END_WR1;
                        end
                        else
                        begin
                            next_r.cyc = BSE_CYC_RD;
                            next_r.nbit = 5'h01;
                        end
                    end
                    else
                    begin
                        next_r.cyc = BSE_CYC_RD;
                        next_r.nbit = r.nbit + 5'h01;
                    end
                end
                BSE_END_WR1:
                begin
                    next_r.cyc = BSE_CYC_WR;
                    next_r.bit_val = 1'b1; // ends read, device to standby [R8] [R22]
                    next_r.st = BSE_DONE;
                end
                BSE_PG_RD1:
                begin
                    next_r.cyc = BSE_CYC_RD; // closes page load [R15]
                    next_r.st = BSE_PG_WR1;
                end
                BSE_PG_WR1:
                begin
                    next_r.cyc = BSE_CYC_WR;
                    next_r.bit_val = 1'b1; // [R15]
                    next_r.st = BSE_PG_RD2;
                end
                BSE_PG_RD2:
                begin
                    next_r.cyc = BSE_CYC_RD; // launches programming [R15]
                    next_r.poll = '0;
                    next_r.st = BSE_POLL;
                end
                BSE_POLL:
                begin
                    // low while busy, high when complete; the launch read is no poll, so its
                    // level is skipped; protect low makes the first poll high [R19] [R2] [R21]
                    next_r.poll = r.poll + 32'h1;
                    if (r.sync2 && r.poll != 32'h0)
                    begin
                        next_r.st = BSE_DONE;
                    end
                    else if (r.poll >= 32'(POLL_LIMIT))
                    begin
                        next_r.tmo = 1'b1;
                        next_r.st = BSE_DONE;
                    end
                    else
                    begin
                        next_r.cyc = BSE_CYC_RD;
                    end
                end
                BSE_DONE:
                begin
                    next_r.done = 1'b1;
                    next_r.st = BSE_IDLE;
                end
                default:
                begin
                    next_r.st = BSE_IDLE;
                end
            endcase
            // drive the strobes of a newly issued cycle
            if (next_r.cyc != r.cyc || cyc_end)
            begin
                next_r.ph = 4'h0;
                if (next_r.cyc == BSE_CYC_RD)
                begin
                    // only output strobe low, device drives data [R4] [R5]
                    next_r.cen = 1'b0;
                    next_r.oen = 1'b0;
                    next_r.wen = 1'b1;
                    next_r.doen = 1'b1;
                end
                else if (next_r.cyc == BSE_CYC_WR)
                begin
                    next_r.cen = 1'b0;
                    next_r.wen = 1'b0;
                    next_r.oen = 1'b1; // never both strobes low [R5]
                    next_r.doen = 1'b0;
                    next_r.dout = next_r.bit_val;
                end
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            r <= '0;
            r.cen <= 1'b1; // select high at reset [R1]
            r.oen <= 1'b1;
            r.wen <= 1'b1;
            r.doen <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign WDATA_TAKE = r.take;
    assign RDATA = r.rdata;
    assign RDATA_VALID = r.rvalid;
    assign BUSY = (r.st != BSE_IDLE);
    assign DONE = r.done;
    assign TIMEOUT = r.tmo;
    assign CE_N = r.cen;
    assign OE_N = r.oen;
    assign WE_N = r.wen;
    assign IO_OUT = r.dout;
    assign IO_OE_N = r.doen;
endmodule

// [hw/bse_map.svh]
// Device and bus rules this block works with
// [R1] chip select high: device ignores strobes, floats
// [R2] protect low blocks new programming cycles
// [R3] data captured at first rising strobe
// [R4] device drives data only when output strobe+select low
// [R5] host never lowers write and output strobes together
// [R6] read starts with sixteen address writes, MSB first
// [R7] eight read cycles return one byte
// [R8] write one after byte ends read
// [R9] address increments per byte, wraps to zero
// [R10] read, write zero, read is reset
// [R11] reset effective after write-zero unless programming
// [R12] reads after reset return high until addressed
// [R13] host issues reset before every sequence
// [R14] write: reset, address, bytes, start command
// [R15] read, write one, read starts programming
// [R16] 64-byte pages wrap on low six bits
// [R17] partial write sequence never starts programming
// [R18] programming end or invalid write clears latch
// [R19] reads during programming return low, then high
// [R20] sequence state static while select high
// [R21] programming takes about two milliseconds
// [R22] illegal patterns drop device to idle
// [R23] array is 32768 bytes, address MSB ignored
`ifndef BSE_MAP_SVH
`define BSE_MAP_SVH
// ----------------------------------------
// protocol and timing constants
// ----------------------------------------
`define BSE_ADDR_BITS 16
`define BSE_BYTE_BITS 8
`define BSE_PAGE_BYTES 64
`define BSE_CLK_MHZ 25
`define BSE_PROG_TIME_US 2000
`define BSE_POLL_LIMIT ((`BSE_PROG_TIME_US) * (`BSE_CLK_MHZ) * 4)
`define BSE_PHASE_CYCLES 2
`endif

// [hw/bse_pkg.sv]
package bse_pkg;
    typedef enum {
        BSE_IDLE, BSE_RST_RD1, BSE_RST_WR0, BSE_RST_RD2,
        BSE_ADDR, BSE_RDATA, BSE_WDATA, BSE_END_WR1,
        BSE_PG_RD1, BSE_PG_WR1, BSE_PG_RD2, BSE_POLL, BSE_DONE
    } bse_state_e;
    typedef enum logic [1:0] {BSE_CYC_NONE, BSE_CYC_RD, BSE_CYC_WR} bse_cyc_e;
endpackage

// [test/bse_host_properties.sv]
`timescale 1ns/1ps
module bse_host_chk (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic START,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic CE_N,
    input wire logic OE_N,
    input wire logic WE_N,
    input wire logic IO_OE_N
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    // strobe relations inside one bus cycle
    chk_strobe_excl: assert property (!CE_N |-> (OE_N || WE_N))
        else $error("write and output strobes low together");
    chk_oe_in_ce: assert property (!OE_N |-> !CE_N)
        else $error("output strobe low outside select");
    chk_no_fight: assert property (!OE_N |-> IO_OE_N)
        else $error("host drives data during a read cycle");
    chk_we_capture: assert property ($rose(WE_N) |-> !CE_N && $past(IO_OE_N) == 1'b0)
        else $error("write cycle not closed by write strobe with data driven");
    chk_ce_last: assert property ($rose(CE_N) |-> OE_N && WE_N)
        else $error("select rose before the strobes");
    // framing of whole operations
    chk_first_read: assert property (START && !BUSY |=> ##1 (!CE_N && !OE_N && WE_N))
        else $error("operation does not open with a read cycle");
    chk_idle_quiet: assert property (!BUSY && !$past(BUSY) |-> CE_N && OE_N && WE_N && IO_OE_N)
        else $error("bus active while idle");
    chk_done_idle: assert property ($rose(DONE) |-> CE_N && OE_N && WE_N)
        else $error("done raised inside a bus cycle");
endmodule
bind bse_host bse_host_chk u_chk (.SYS_CLK, .RST, .START, .BUSY, .DONE, .CE_N, .OE_N, .WE_N, .IO_OE_N);

// [test/bse_dev_model.sv]
`timescale 1ns/1ps
module bse_dev_model #(
    parameter int PROG_CYCLES = 100
)(
    input wire logic SYS_CLK,
    input wire logic PROTECT_N,
    input wire logic CE_N,
    input wire logic OE_N,
    input wire logic WE_N,
    input wire logic IO_WIRE,
    output logic IO_DEV
);
    logic [7:0] mem [0:32767];
    logic [7:0] pg [0:63];
    logic [63:0] ld = '0;
    logic [14:0] addr = '0;
    logic [7:0] wb = '0;
    logic wel = 1'b0, last_rd = 1'b0, held = 1'b0, io_q = 1'b0;
    // st: 0 idle, 1 address, 2 read data, 3 page load, 4 load closed, 5 start armed
    int st = 0, cnt = 0, busy = 0;
    initial
        for (int a = 0; a < 32768; a++)
            mem[a] = 8'(a * 7 + 3);
    // released line shows the inverse of its last level, never a stale copy
    assign IO_DEV = (!CE_N && !OE_N) ? (busy > 0 ? 1'b0 : st == 2 ? mem[addr][7 - cnt] : 1'b1) : ~held;
    // data sampled a clock early so it cannot race the strobe update
    always @(posedge SYS_CLK)
    begin
        io_q <= IO_WIRE;
        if (!CE_N && !OE_N) held <= IO_DEV;
        if (busy == 1) wel = 1'b0;
        if (busy > 0) busy--;
    end
    // write cycle ends at the write strobe edge
    always @(posedge WE_N)
    begin
        if (!CE_N && busy == 0)
        begin
            if (last_rd && !io_q)
            begin
                st = 1;
                cnt = 0;
                wel = 1'b1;
                ld = '0;
            end
            else if (last_rd && st == 4)
                st = 5;
            else if (st == 1 && !last_rd)
            begin
                addr = {addr[13:0], io_q};
                cnt++;
                st = (cnt == 16) ? 2 : 1;
                cnt = cnt % 16;
            end
            else if ((st == 2 || st == 3) && !last_rd)
            begin
                st = 3;
                wb = {wb[6:0], io_q};
                cnt = (cnt + 1) % 8;
                if (cnt == 0)
                begin
                    pg[addr[5:0]] = wb;
                    ld[addr[5:0]] = 1'b1;
                    addr[5:0] = addr[5:0] + 6'h01;
                end
            end
            else
            begin
                st = 0;
                wel = 1'b0;
            end
        end
        last_rd = 1'b0;
    end
    // read cycle ends at the output strobe edge; reset tail read is inert
    always @(posedge OE_N)
    begin
        if (!CE_N && busy == 0 && !(st == 1 && cnt == 0))
        begin
            if (st == 2)
            begin
                cnt = (cnt + 1) % 8;
                if (cnt == 0) addr++;
            end
            else if (st == 3 && cnt == 0 && ld != '0)
                st = 4;
            else if (st == 5 && wel && PROTECT_N)
            begin
                for (int o = 0; o < 64; o++)
                    if (ld[o]) mem[{addr[14:6], 6'(o)}] = pg[o];
                busy = PROG_CYCLES;
                st = 0;
            end
            else
                st = 0;
        end
        if (!CE_N && !(st == 1 && cnt == 0)) last_rd = 1'b1;
    end
endmodule

// [test/tb_bit_serial_bus_eeprom.sv]
`timescale 1ns/1ps
module tb_bit_serial_bus_eeprom;
    logic SYS_CLK = 1'b0;
    logic RST = 1'b1;
    logic START = 1'b0;
    logic WRITE = 1'b0;
    logic [15:0] ADDR = '0;
    logic [6:0] COUNT = 7'h01;
    logic [7:0] WDATA = '0;
    logic protect_n = 1'b1;
    logic WDATA_TAKE, RDATA_VALID, BUSY, DONE, TIMEOUT, CE_N, OE_N, WE_N, IO_OUT, IO_OE_N, io_dev;
    logic [7:0] RDATA;
    logic [7:0] q [$];
    int fail_count = 0;
    int n_checks = 0;
    wire IO_IN = !IO_OE_N ? IO_OUT : io_dev;
    // 25 MHz system clock
    always #20 SYS_CLK = ~SYS_CLK;
    // short poll limit keeps a stuck device from stalling the run
    bse_host #(.POLL_LIMIT(400), .PHASE(2)) dut (.SYS_CLK, .RST, .START, .WRITE, .ADDR, .COUNT,
        .WDATA, .WDATA_TAKE, .RDATA, .RDATA_VALID, .BUSY, .DONE, .TIMEOUT, .CE_N, .OE_N, .WE_N,
        .IO_IN, .IO_OUT, .IO_OE_N);
    bse_dev_model #(.PROG_CYCLES(100)) u_dev (.SYS_CLK, .PROTECT_N(protect_n), .CE_N, .OE_N, .WE_N,
        .IO_WIRE(IO_IN), .IO_DEV(io_dev));
    function automatic logic [7:0] pat(input int a);
        return 8'(a * 7 + 3);
    endfunction
    task automatic report_and_stop();
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // one operation; q holds bytes to send or bytes expected back
    task automatic op(input logic wr, input logic [15:0] a, input int n);
        int i;
        int k;
        i = 0;
        for (k = 0; k < 50 && BUSY !== 1'b0; k++)
            @(negedge SYS_CLK);
        @(negedge SYS_CLK);
        START = 1'b1;
        WRITE = wr;
        ADDR = a;
        COUNT = 7'(n);
        WDATA = q[0];
        for (k = 0; k < 5000 && DONE !== 1'b1; k++)
        begin
            @(negedge SYS_CLK);
            if (BUSY === 1'b1) START = 1'b0;
            if (WDATA_TAKE === 1'b1) i++;
            if (WDATA_TAKE === 1'b1) WDATA = q[i % n];
            if (RDATA_VALID === 1'b1) check("RDATA", q[i], RDATA);
            if (RDATA_VALID === 1'b1) i++;
        end
        check("byte count", 8'(n), 8'(i));
        check("DONE", 8'h01, {7'h00, DONE});
    endtask
    // read across the top of the array; address msb must be ignored
    task automatic t_read_wrap();
        q = '{pat(32'h7FFE), pat(32'h7FFF), pat(0)};
        op(1'b0, 16'hFFFE, 3);
    endtask
    // page load running past the page end, then both halves read back
    task automatic t_page_wrap();
        q = '{8'hA1, 8'hB2, 8'hC3, 8'hD4};
        op(1'b1, 16'h017E, 4);
        check("TIMEOUT", 8'h00, {7'h00, TIMEOUT});
        q = '{8'hA1, 8'hB2, pat(32'h0180)};
        op(1'b0, 16'h017E, 3);
        q = '{8'hC3, 8'hD4, pat(32'h0142)};
        op(1'b0, 16'h0140, 3);
    endtask
    // protected page write must leave the array untouched and still finish
    task automatic t_protect();
        protect_n = 1'b0;
        q = '{8'h5A, 8'h6B};
        op(1'b1, 16'h0200, 2);
        check("TIMEOUT", 8'h00, {7'h00, TIMEOUT});
        protect_n = 1'b1;
        q = '{pat(32'h0200), pat(32'h0201)};
        op(1'b0, 16'h0200, 2);
    endtask
    // reset in mid-read; the next read must start from a clean state
    task automatic t_reset_mid();
        int k;
        START = 1'b1;
        WRITE = 1'b0;
        ADDR = 16'h0300;
        COUNT = 7'h02;
        for (k = 0; k < 500 && RDATA_VALID !== 1'b1; k++)
        begin
            @(negedge SYS_CLK);
            if (BUSY === 1'b1) START = 1'b0;
        end
        check("RDATA", pat(32'h0300), RDATA);
        RST = 1'b1;
        @(negedge SYS_CLK);
        check("BUSY in reset", 8'h00, {7'h00, BUSY});
        check("CE_N in reset", 8'h01, {7'h00, CE_N});
        @(negedge SYS_CLK);
        RST = 1'b0;
        q = '{pat(32'h0300), pat(32'h0301)};
        op(1'b0, 16'h0300, 2);
    endtask
    // main sequence
    initial
    begin
        repeat (10) @(posedge SYS_CLK);
        @(negedge SYS_CLK);
        RST = 1'b0;
        t_read_wrap();
        t_page_wrap();
        t_protect();
        t_reset_mid();
        report_and_stop();
    end
    // watchdog well beyond the roughly 1500 cycles the tests need
    initial
    begin
        #400000;
        fail_count++;
        report_and_stop();
    end
endmodule
